// file: rtl/tape_status_flags.sv
// Sticky condition flags of the tape controller
`include "tape_status_params.svh"
`default_nettype none
module tape_status_flags (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Events from the transport and datapath
  input  wire logic motion_start,
  input  wire logic motion_stop,
  input  wire logic eot_fwd,
  input  wire logic eot_back,
  input  wire logic unit_online,
  input  wire logic unit_change,
  input  wire logic op_start,
  input  wire logic mark_seen,
  input  wire logic buf_ready,
  input  wire logic data_taken,
  input  wire logic odd_block_end,
  input  wire logic miss_window,
  input  wire logic late_write,
  input  wire logic check_fail,
  // Flags out
  tape_flags_if.source flags
);
  import tape_status_pkg::*;
  typedef struct packed {
    logic busy;
    logic end_tape;
    logic tape_mark;
    logic buf_na;
    logic len_err;
    logic lost_data;
    logic parity_err;
  } flag_state_s;
  flag_state_s state_reg;
  flag_state_s state_next;
  // Sets win over clears so an event on the clearing cycle survives
  always_comb begin
    state_next = state_reg;
    if (motion_stop)
      state_next.busy = 1'b0;
    if (motion_start)
      state_next.busy = 1'b1;
    if (eot_back || !unit_online || unit_change)
      state_next.end_tape = 1'b0;
    if (eot_fwd)
      state_next.end_tape = 1'b1;
    // A new operation clears the results of the previous one
    if (op_start) begin
      state_next.tape_mark  = 1'b0;
      state_next.len_err    = 1'b0;
      state_next.lost_data  = 1'b0;
      state_next.parity_err = 1'b0;
    end
    if (mark_seen)
      state_next.tape_mark = 1'b1;
    if (buf_ready)
      state_next.buf_na = 1'b0;
    if (data_taken)
      state_next.buf_na = 1'b1;
    if (odd_block_end)
      state_next.len_err = 1'b1;
    if (miss_window || late_write)
      state_next.lost_data = 1'b1;
    if (check_fail)
      state_next.parity_err = 1'b1;
  end
  // Buffer starts unavailable until the datapath says otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg        <= '0;
      state_reg.buf_na <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end
  assign flags.busy       = state_reg.busy;
  assign flags.end_tape   = state_reg.end_tape;
  assign flags.tape_mark  = state_reg.tape_mark;
  assign flags.buf_na     = state_reg.buf_na;
  assign flags.len_err    = state_reg.len_err;
  assign flags.lost_data  = state_reg.lost_data;
  assign flags.parity_err = state_reg.parity_err;
endmodule
`default_nettype wire

// file: rtl/tape_status_response.sv
// I/O bus response: status-in, address-in, data acks and service request
`include "tape_status_params.svh"
`default_nettype none
module tape_status_response #(
  parameter logic [7:0] OWN_ADDR = 8'h07
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // I/O instruction strobes, one cycle each
  input  wire logic                  status_in_instruction,
  input  wire logic                  address_in_instruction,
  input  wire logic                  data_in_instruction,
  input  wire logic                  data_out_instruction,
  input  wire logic                  control_instruction,
  input  wire logic [7:0]            instruction_select_field,
  // Control command class, valid with control_instruction
  input  wire logic                  cmd_is_read,
  input  wire logic                  cmd_is_write,
  input  wire logic                  cmd_is_backspace,
  input  wire logic                  cmd_is_rewind,
  // Precedence chain: high when no higher requester
  input  wire logic                  precedence_in,
  // Transport levels
  input  wire logic                  unit_powered,
  input  wire logic                  tape_loaded,
  input  wire logic                  unit_online,
  input  wire logic                  at_load_point,
  input  wire logic                  write_ring,
  input  wire logic                  rewinding,
  // Transport and datapath events, one cycle each
  input  wire logic                  motion_start,
  input  wire logic                  motion_stop,
  input  wire logic                  eot_fwd,
  input  wire logic                  eot_back,
  input  wire logic                  unit_change,
  input  wire logic                  mark_seen,
  input  wire logic                  buf_ready,
  input  wire logic                  odd_block_end,
  input  wire logic                  miss_window,
  input  wire logic                  end_block_started,
  input  wire logic                  end_of_operation,
  input  wire logic                  check_fail,
  // Buffer word from the datapath for data-in
  input  wire logic [15:0]           read_word,
  // Answers to the processor
  output logic                       acknowledge,
  output logic                       service_request,
  output logic [15:0]                accumulator_out,
  output logic                       accumulator_valid,
  // Accepted commands to the datapath
  output logic                       command_accepted,
  output logic                       data_out_accepted
);
  import tape_status_pkg::*;
  // Strobes are sampled and answered through the register on the same edge.
  // Answers are withdrawn one edge later; the host reads in between.
  // Limitation: a ready event in a drop cycle raises the request again,
  // so the host may see a request just after reading status.

  typedef struct packed {
    logic         ack;
    logic         srq;
    word_t        acc;
    logic         acc_valid;
    logic         cmd_ok;
    logic         dout_ok;
    last_cmd_e    last_cmd;
  } resp_state_s;

  resp_state_s state_reg;
  resp_state_s state_next;

  tape_flags_if flags ();
  logic [15:0]  status_word;
  logic         addr_hit;
  logic         din_ok;
  logic         dout_ok;
  logic         ctl_ok;
  logic         op_start;
  logic         late_write;
  word_t        din_word;

  // Full eight-bit select compare; shared by every addressed instruction
  function automatic logic match_addr(input logic [7:0] sel);
    match_addr = (sel == OWN_ADDR);
  endfunction

  assign addr_hit = match_addr(instruction_select_field);

  // Nets of the refusal and request logic
  logic         protect_on;
  logic         data_taken;
  logic         own_status;
  logic         addr_answer;
  logic         buf_free;
  logic         last_rd;
  logic         last_wr;
  logic         srq_drop;
  logic         srq_raise;
  // Answer mux outputs
  word_t        answer_word;
  logic         answer_valid;

  // Width of the byte that a short block leaves empty
  localparam int LOW_W = $bits(`LOW_BYTE_ZERO);

  // Command refusals kept in one place for the control decode
  function automatic logic cmd_refused(
    input logic busy,
    input logic load_point,
    input logic protect,
    input logic back,
    input logic rew,
    input logic wr
  );
    cmd_refused = 1'b0;
    // Any new command waits for tape motion to end
    if (busy)
      cmd_refused = 1'b1;

    // Nothing lies behind the load point
    if (load_point && (back || rew))
      cmd_refused = 1'b1;

    // No ring, no writing
    if (protect && wr)
      cmd_refused = 1'b1;
  endfunction

  // Class of an accepted command for the later data acknowledges
  function automatic last_cmd_e cmd_class(
    input logic rd,
    input logic wr
  );
    if (rd) begin
      cmd_class = last_read;
    end else if (wr) begin
      cmd_class = last_write;
    end else begin
      cmd_class = last_none;
    end
  endfunction

  // Own address placed in the low bits, the rest zero
  function automatic word_t addr_word(input logic [7:0] a);
    addr_word              = '0;
    addr_word[`ADDR_W-1:0] = a;
  endfunction

  // Sticky condition flags, set by events, cleared by new operations or by their own clearing events
  tape_status_flags tape_status_flags_inst (
    // Clock and reset
    .ref_clk       (ref_clk),
    .rst           (rst),
    // Transport events
    .motion_start  (motion_start),
    .motion_stop   (motion_stop),
    .eot_fwd       (eot_fwd),
    .eot_back      (eot_back),
    .unit_online   (unit_online),
    .unit_change   (unit_change),
    .mark_seen     (mark_seen),
    // Operation and data events
    .op_start      (op_start),
    .buf_ready     (buf_ready),
    .data_taken    (data_taken),
    .odd_block_end (odd_block_end),
    .miss_window   (miss_window),
    .late_write    (late_write),
    .check_fail    (check_fail),
    // Flags out
    .flags         (flags)
  );

  // Status word from live transport levels and the held flags
  tape_status_word tape_status_word_inst (
    // Transport levels
    .unit_powered  (unit_powered),
    .tape_loaded   (tape_loaded),
    .unit_online   (unit_online),
    .at_load_point (at_load_point),
    .write_ring    (write_ring),
    .rewinding     (rewinding),
    // Flags in
    .flags         (flags),
    // Word out
    .word          (status_word)
  );

  // File protect is read back from the word so both agree
  assign protect_on = status_word[`SB_PROTECT];

  // Status-in aimed here by the full select field
  assign own_status = status_in_instruction && addr_hit;

  // Address-in looks only at our request and the precedence chain
  assign addr_answer = address_in_instruction
                       && state_reg.srq
                       && precedence_in;

  // Buffer and last command qualifiers for both data paths
  assign buf_free = !flags.buf_na;
  assign last_rd  = (state_reg.last_cmd == last_read);
  assign last_wr  = (state_reg.last_cmd == last_write);

  // Data transfers run during motion, so busy gates commands only
  assign din_ok = data_in_instruction
                  && addr_hit
                  && buf_free
                  && last_rd;

  // Data after the block closed is refused
  // and flagged as lost data
  assign late_write = data_out_instruction
                      && addr_hit
                      && last_wr
                      && (end_block_started || end_of_operation);

  // Data-out needs an empty buffer and an open write
  assign dout_ok = data_out_instruction
                   && addr_hit
                   && buf_free
                   && !late_write
                   && last_wr;

  // Control commands pass the refusal checks before acceptance
  assign ctl_ok = control_instruction
                  && addr_hit
                  && !cmd_refused(flags.busy,
                                  at_load_point,
                                  protect_on,
                                  cmd_is_backspace,
                                  cmd_is_rewind,
                                  cmd_is_write);

  // Any accepted command opens a new operation
  // and clears the results of the one before
  assign op_start = ctl_ok;

  // Each executed data instruction empties or fills the buffer
  assign data_taken = din_ok || dout_ok;

  // Request drops on status-in, address-in and every data transfer
  assign srq_drop = own_status
                    || address_in_instruction
                    || data_taken;

  // Request returns when the buffer is ready or motion ends the job
  assign srq_raise = buf_ready
                     || (motion_stop && end_of_operation);

  // Short blocks leave the low byte of the last word empty;
  // the host tells them apart by the length error flag
  always_comb begin
    din_word = read_word;
    if (flags.len_err) begin
      din_word[LOW_W-1:0] = `LOW_BYTE_ZERO;
    end
  end

  // Answer word; at most one instruction is on the bus per cycle
  always_comb begin
    answer_word  = '0;
    answer_valid = 1'b0;

    if (own_status) begin
      answer_word  = status_word;
      answer_valid = 1'b1;
    end

    if (addr_answer) begin
      answer_word  = addr_word(OWN_ADDR);
      answer_valid = 1'b1;
    end

    if (din_ok) begin
      answer_word  = din_word;
      answer_valid = 1'b1;
    end
  end

  // Next state: answers stand for a single cycle, then fall back
  always_comb begin
    state_next = state_reg;
    // Pulses drop every cycle; the word follows the answer mux
    state_next.ack       = 1'b0;
    state_next.acc       = answer_word;
    state_next.acc_valid = answer_valid;
    state_next.cmd_ok    = 1'b0;
    state_next.dout_ok   = 1'b0;

    // Status-in and address-in never raise the acknowledge
    // Data-in is acknowledged along with its word
    if (din_ok) begin
      state_next.ack = 1'b1;
    end

    // Data-out is taken by the datapath on the next cycle
    if (dout_ok) begin
      state_next.ack     = 1'b1;
      state_next.dout_ok = 1'b1;
    end

    // Accepted commands are acknowledged and their class remembered
    if (ctl_ok) begin
      state_next.ack      = 1'b1;
      state_next.cmd_ok   = 1'b1;
      state_next.last_cmd = cmd_class(cmd_is_read, cmd_is_write);
    end

    // Raising wins, so a ready event in a drop cycle is not lost
    if (srq_drop) begin
      state_next.srq = 1'b0;
    end
    if (srq_raise) begin
      state_next.srq = 1'b1;
    end
  end

  // One register for the whole response state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // No answer, no request, no command class
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Handshake answers
  assign acknowledge       = state_reg.ack;
  assign service_request   = state_reg.srq;

  // Accepted-command strobes to the datapath
  assign command_accepted  = state_reg.cmd_ok;
  assign data_out_accepted = state_reg.dout_ok;

  // Data answers
  assign accumulator_out   = state_reg.acc;
  assign accumulator_valid = state_reg.acc_valid;
endmodule
`default_nettype wire

// file: rtl/tape_status_word.sv
// Assembles the status word from live transport levels and held flags
`include "tape_status_params.svh"
`default_nettype none
module tape_status_word (
  // Transport levels
  input  wire logic        unit_powered,
  input  wire logic        tape_loaded,
  input  wire logic        unit_online,
  input  wire logic        at_load_point,
  input  wire logic        write_ring,
  input  wire logic        rewinding,
  // Held flags
  tape_flags_if.sink       flags,
  // Assembled word
  output logic [15:0]      word
);
  import tape_status_pkg::*;
  // Unassigned positions stay zero; each flag is a plain level
  always_comb begin
    word                      = '0;
    word[`SB_NOT_READY]       = !unit_powered || !tape_loaded
                                || !unit_online;
    word[`SB_BUSY]            = flags.busy;
    word[`SB_LOAD_POINT]      = at_load_point;
    word[`SB_END_TAPE]        = flags.end_tape;
    word[`SB_PROTECT]         = !write_ring;
    word[`SB_TAPE_MARK]       = flags.tape_mark;
    word[`SB_REWINDING]       = rewinding;
    word[`SB_BUF_NA]          = flags.buf_na;
    word[`SB_LEN_ERR]         = flags.len_err;
    word[`SB_LOST_DATA]       = flags.lost_data;
    word[`SB_PARITY]          = flags.parity_err;
  end
endmodule
`default_nettype wire

// file: shared/tape_flags_if.sv
// Condition flags passed from the flag tracker to the status assembler
`default_nettype none
interface tape_flags_if;
  logic busy;
  logic end_tape;
  logic tape_mark;
  logic buf_na;
  logic len_err;
  logic lost_data;
  logic parity_err;
  modport source (output busy, end_tape, tape_mark, buf_na, len_err,
                  lost_data, parity_err);
  modport sink (input busy, end_tape, tape_mark, buf_na, len_err,
                lost_data, parity_err);
endinterface
`default_nettype wire

// file: shared/tape_status_params.svh
// Constants for the tape controller status and address response block
// What this block does
// - Status-in answers only on full address match
// - Flags high when true, low otherwise
// - Bit 9: unpowered, unloaded or offline
// - Bit 8: busy from motion start until stop
// - Refuse new control commands while busy
// - Bit 12 load point; refuse backspace, rewind
// - Bit 14 end of tape, sticky, non-blocking
// - Bit 11 file protect; refuse writes
// - Bit 15 tape mark read, spaced or written
// - Bit 6 set while rewinding
// - Bit 5 buffer unavailable set/clear
// - Refuse data transfers while buffer unavailable
// - Bit 4 odd length, low byte zero
// - Bit 13 lost data on missed window
// - Bit 10 parity error, read and write
// - Never acknowledge status-in
// - Status-in drops pending service request
// - Address-in ignores select field
// - Address out only if requesting, highest
// - Address-in: no acknowledge, drop request
// - Data acks need buffer state, last command
// - Reissue request when ready or motion stops at end of operation
`ifndef TAPE_STATUS_PARAMS_SVH
`define TAPE_STATUS_PARAMS_SVH
`define SB_LEN_ERR     4
`define SB_BUF_NA      5
`define SB_REWINDING   6
`define SB_BUSY        8
`define SB_NOT_READY   9
`define SB_PARITY     10
`define SB_PROTECT    11
`define SB_LOAD_POINT 12
`define SB_LOST_DATA  13
`define SB_END_TAPE   14
`define SB_TAPE_MARK  15
`define STATUS_W      16
`define ADDR_W         8
`define LOW_BYTE_ZERO 8'h00
`endif

// file: shared/tape_status_pkg.sv
// Types shared by the tape status block
package tape_status_pkg;
  typedef enum logic [1:0] {
    last_none,
    last_read,
    last_write
  } last_cmd_e;
  typedef logic [15:0] word_t;
endpackage

// file: tb/host_bus_model.sv
// Host processor model issuing one-cycle I/O instructions
`default_nettype none
module host_bus_model (
  // Clock and answers
  input  wire logic        ref_clk, acknowledge, accumulator_valid,
  input  wire logic [15:0] accumulator_out,
  // Instruction strobes and qualifiers
  output wire logic        status_in_instruction, address_in_instruction,
  output wire logic        data_in_instruction, data_out_instruction,
  output wire logic        control_instruction, precedence_in,
  output wire logic        cmd_is_read, cmd_is_write,
  output wire logic        cmd_is_backspace, cmd_is_rewind,
  output wire logic [7:0]  instruction_select_field
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  k_r = 5'h00;
  logic [4:0]  c_r = 5'h10;
  logic [7:0]  s_r = 8'h00;
  logic        ack_seen, val_seen;
  logic [15:0] acc_seen;
  // Idle select and command-class lines show an inverted pattern; strobes return to zero and precedence_in holds
  assign {status_in_instruction, address_in_instruction, data_in_instruction,
          data_out_instruction, control_instruction} = k_r;
  assign {precedence_in, cmd_is_read, cmd_is_write, cmd_is_backspace,
          cmd_is_rewind} = c_r;
  assign instruction_select_field = s_r;
  // One strobe cycle, answer read in the cycle after
  task automatic io(input logic [4:0] k, input logic [7:0] sel,
                    input logic [4:0] cmd);
    @(negedge ref_clk);
    k_r <= k;
    s_r <= sel;
    c_r <= cmd;
    @(negedge ref_clk);
    ack_seen = acknowledge;
    val_seen = accumulator_valid;
    acc_seen = accumulator_out;
    k_r <= 5'h00;
    s_r <= ~sel;
    c_r <= {cmd[4], ~cmd[3:0]};
  endtask
endmodule
`default_nettype wire

// file: tb/tape_status_response_chk.sv
// Assertions on the I/O bus answers of the tape status block
`default_nettype none
module tape_status_response_chk #(
  parameter logic [7:0] OWN_ADDR = 8'h07
) (
  // Clock, reset and instructions
  input wire logic        ref_clk, rst, status_in_instruction,
  input wire logic        address_in_instruction, precedence_in,
  input wire logic [7:0]  instruction_select_field,
  // Transport levels
  input wire logic        at_load_point, write_ring, rewinding,
  // Answers
  input wire logic        acknowledge, service_request, accumulator_valid,
  input wire logic [15:0] accumulator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Status read aimed at this controller
  sequence own_esi;
    status_in_instruction && instruction_select_field == OWN_ADDR;
  endsequence
  chk_esi_no_ack:
    assert property (status_in_instruction |=> !acknowledge)
    else $error("ack after status-in");
  chk_esi_drops_req:
    assert property (own_esi |=> !service_request)
    else $error("request kept after status-in");
  chk_foreign_silent:
    assert property (status_in_instruction &&
      instruction_select_field != OWN_ADDR |=> !accumulator_valid)
    else $error("answered foreign address");
  chk_live_bits:
    assert property (own_esi |=> accumulator_valid &&
      accumulator_out[12] == $past(at_load_point) &&
      accumulator_out[11] == !$past(write_ring) &&
      accumulator_out[6] == $past(rewinding))
    else $error("live status bits wrong");
  chk_spare_zero:
    assert property (own_esi |=> !accumulator_out[7] &&
      accumulator_out[3:0] == 4'h0)
    else $error("spare status bits set");
  chk_eai_quiet:
    assert property (address_in_instruction |=>
      !acknowledge && !service_request)
    else $error("address-in ack or request");
  chk_addr_out:
    assert property (address_in_instruction && service_request &&
      precedence_in |=> accumulator_valid &&
      accumulator_out[7:0] == OWN_ADDR)
    else $error("own address not returned");
  chk_no_addr:
    assert property (address_in_instruction &&
      !(service_request && precedence_in) |=> !accumulator_valid)
    else $error("address returned without request");
endmodule
bind tape_status_response tape_status_response_chk #(.OWN_ADDR(OWN_ADDR))
  tape_status_response_chk_inst (.*);
`default_nettype wire

// file: tb/tape_status_response_tb.sv
// Self-checking bench for the tape status and address response block
`default_nettype none
module tape_status_response_tb;
  import tape_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ADDR = 8'h07;
  localparam int EVB[5] = '{2, 5, 7, 8, 11};
  localparam int SBT[5] = '{14, 15, 4, 13, 10};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic unit_powered = 1'b1, tape_loaded = 1'b1, unit_online = 1'b1;
  logic at_load_point = 1'b1, write_ring = 1'b1, rewinding = 1'b0;
  logic [11:0] ev = 12'h000;
  word_t read_word = 16'h0000;
  word_t exp_w, acc_s;
  logic ack_s, val_s;
  int errors = 0, n_checks = 0;
  // Transport events fanned out from one vector
  wire logic motion_start = ev[0], motion_stop = ev[1], eot_fwd = ev[2];
  wire logic eot_back = ev[3], unit_change = ev[4], mark_seen = ev[5];
  wire logic buf_ready = ev[6], odd_block_end = ev[7], miss_window = ev[8];
  wire logic end_block_started = ev[9], end_of_operation = ev[10];
  wire logic check_fail = ev[11];
  wire logic status_in_instruction, address_in_instruction, precedence_in;
  wire logic data_in_instruction, data_out_instruction, control_instruction;
  wire logic cmd_is_read, cmd_is_write, cmd_is_backspace, cmd_is_rewind;
  wire logic acknowledge, service_request, accumulator_valid;
  wire logic command_accepted, data_out_accepted;
  wire logic [7:0] instruction_select_field;
  wire word_t accumulator_out;
  tape_status_response #(.OWN_ADDR(ADDR)) tape_status_response_inst (.*);
  host_bus_model host_bus_model_inst (.*);
  task automatic chk(input word_t seen, input word_t want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Instruction kinds: status, address, data-in, data-out, control
  task automatic op(input logic [4:0] k, input logic [7:0] s,
                    input logic [4:0] c);
    host_bus_model_inst.io(k, s, c);
    ack_s = host_bus_model_inst.ack_seen;
    val_s = host_bus_model_inst.val_seen;
    acc_s = host_bus_model_inst.acc_seen;
  endtask
  task automatic pulse(input logic [11:0] m);
    @(negedge ref_clk);
    ev <= m;
    @(negedge ref_clk);
    ev <= 12'h000;
  endtask
  // Status read compared against the running expected word
  task automatic status();
    op(5'h10, ADDR, 5'h10);
    chk({15'h0, ack_s}, 16'h0);
    chk(acc_s, exp_w);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Watchdog at 5000 cycles, well beyond the fewer than a hundred cycles the tests need
  initial begin
    #50000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    pulse(12'h040);
    exp_w = 16'h1000;
    status();
    op(5'h10, ~ADDR, 5'h10);
    chk({15'h0, val_s}, 16'h0);
    op(5'h01, ADDR, 5'h11);
    chk({15'h0, ack_s}, 16'h0);
    write_ring = 1'b0;
    exp_w[11] = 1'b1;
    op(5'h01, ADDR, 5'h14);
    chk({15'h0, ack_s}, 16'h0);
    pulse(12'h001);
    exp_w[8] = 1'b1;
    status();
    op(5'h01, ADDR, 5'h18);
    chk({15'h0, ack_s}, 16'h0);
    pulse(12'h402);
    exp_w[8] = 1'b0;
    status();
    chk({15'h0, service_request}, 16'h0);
    pulse(12'h402);
    op(5'h08, 8'h5a, 5'h10);
    chk({8'h00, acc_s[7:0]}, {8'h00, ADDR});
    chk({14'h0, ack_s, service_request}, 16'h0);
    op(5'h08, ADDR, 5'h10);
    chk({15'h0, val_s}, 16'h0);
    op(5'h04, ADDR, 5'h10);
    chk({15'h0, ack_s}, 16'h0);
    for (int i = 0; i < 5; i++) begin
      pulse(12'h001 << EVB[i]);
      exp_w[SBT[i]] = 1'b1;
      status();
    end
    pulse(12'h010);
    exp_w[14] = 1'b0;
    status();
    unit_online = 1'b0;
    rewinding = 1'b1;
    exp_w[9] = 1'b1;
    exp_w[6] = 1'b1;
    status();
    at_load_point = 1'b0;
    write_ring = 1'b1;
    op(5'h01, ADDR, 5'h14);
    chk({14'h0, ack_s, command_accepted}, 16'h0003);
    op(5'h02, ADDR, 5'h10);
    chk({14'h0, ack_s, data_out_accepted}, 16'h0003);
    exp_w = 16'h0260;
    status();
    op(5'h02, ADDR, 5'h10);
    chk({15'h0, ack_s}, 16'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
